// *** include/port_pin_readback_map.svh ***
// Purpose: offsets, field codes and reset values of the port 1 block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   definitions only
`ifndef PORT_PIN_READBACK_MAP_SVH
`define PORT_PIN_READBACK_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_OUTPUT_LATCH   4'h0
`define OFS_PIN_READBACK   4'h4
`define OFS_DIRECTION      4'h8
`define OFS_FUNC_ENABLE    4'hc

// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RST_LATCH          8'h00
`define RST_DIRECTION      8'h00
`define RST_FUNC_ENABLE    4'h0
`define FE_DMA_ACK1_BIT    0
`define FE_PULSE_LSB       1

// ----------------------------------------------------------------
// timer field codes
// ----------------------------------------------------------------
`define MODE_NORMAL        4'h0
`define MODE_PWM1          4'h2
`define MODE_PWM2          4'h3
`define PSC_EXT_CD         3'h7
`define PSC_EXT_C_ALT      3'h5
`define CCLR_OWN_CH2_B     2'h2
`define CCLR_OWN_CH2_A     2'h2
`define CCLR_OWN_CH1_B     2'h2

`endif

// *** include/port_pin_readback_pkg.sv ***
// Purpose: types shared by the port 1 block
// Assumes: nothing
// Notes:   timer and peripheral groups travel as packed structs
package port_pin_readback_pkg;

   // settings mirrored from the timer unit
   typedef struct packed {
      logic [3:0] mode2;
      logic [3:0] io_a2;
      logic [3:0] io_b2;
      logic [1:0] clear2;
      logic [3:0] mode1;
      logic [3:0] io_b1;
      logic [1:0] clear1;
      logic [3:0] mode4;
      logic [2:0] psc0;
      logic [2:0] psc2;
      logic [2:0] psc4;
      logic [2:0] psc5;
   } timer_cfg_s;

   // output levels offered by other units
   typedef struct packed {
      logic timer2_b;
      logic timer2_a;
      logic timer1_b;
      logic pulse15;
      logic pulse14;
      logic pulse13;
      logic dma_ack1;
   } periph_out_s;

   // inputs handed to the timer unit
   typedef struct packed {
      logic capture_b2;
      logic capture_a2;
      logic capture_b1;
      logic ext_clock_d;
      logic ext_clock_c;
   } timer_in_s;

   typedef enum logic [2:0] {
      FN_INPUT,
      FN_LATCH,
      FN_PULSE,
      FN_TIMER,
      FN_DMA
   } pin_fn_e;

endpackage : port_pin_readback_pkg

// *** rtl/port_pin_readback_data_and_pin_select.sv ***
// Purpose: port 1 output latch, pin readback and upper pin function select
// Assumes: classic Wishbone slave, rst_i synchronous active high, 250 MHz clock
// Notes:   pins 4..0 are plain general-purpose pins; outputs all registered
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "port_pin_readback_map.svh"

// Operation
// - eight-bit read/write output latch, reset zero, drives output pins
// - pin readback register is read only and follows the pins
// - readback bit with direction one returns the latch bit
// - readback bit with direction zero returns the pin level
// - upper pins shared with pulse, timer and dma functions
// - pin 7: timer B2 output, else input, latch or pulse output
// - timer pin outputs on compare modes or pwm2 without own clearing
// - pin 7 feeds timer 2 capture B in normal or phase modes
// - pin 7 feeds clock D when channel 0 or 5 prescaler is 111
// - pin 7 feeds clock D when channels 2 and 4 phase count
// - pin 6: timer A2 output, else input, latch or pulse output
// - pin 6 feeds timer 2 capture A when io top bit set
// - pwm mode 1 on channel 2 output A disables output B drive
// - dma ack enable puts acknowledge 1 on pin 5, overriding all
// - pin 5 feeds timer 1 capture B when io field is 10xx
// - pin 5 feeds clock C for prescaler 111, 101 or phase counting
// - write-only direction bits, reset zero, one makes an output
module port_pin_readback_data_and_pin_select
   import port_pin_readback_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic [7:0]  pin_i,
   output logic      [7:0]  pin_out_o,
   output logic      [7:0]  pin_oe_n_o,
   input  wire timer_cfg_s  timer_cfg_i,
   input  wire periph_out_s periph_i,
   output timer_in_s        timer_in_o
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // compare or pwm2 output for one timer pin
   function automatic logic compare_out(input logic [3:0] mode, input logic [3:0] io,
                                        input logic [1:0] clr, input logic [1:0] own);
      logic norm;
      norm = (mode == `MODE_NORMAL) || (mode[3:2] == 2'b01);
      compare_out = (norm && (io[3] == 1'b0) && (io[1:0] != 2'b00))
                    || ((mode == `MODE_PWM2) && (io[1:0] != 2'b00) && (clr != own));
   endfunction : compare_out

   function automatic logic capture_mode(input logic [3:0] mode);
      capture_mode = (mode == `MODE_NORMAL) || (mode[3:2] == 2'b01);
   endfunction : capture_mode

   // general-purpose choice from direction and pulse enable
   function automatic pin_fn_e gp_fn(input logic dir, input logic pulse_en);
      gp_fn = !dir ? FN_INPUT : (pulse_en ? FN_PULSE : FN_LATCH);
   endfunction : gp_fn

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0]  latch;
   logic [7:0]  direction;
   logic [3:0]  func_en;      // bit0 dma ack1 enable, bits 3..1 pulse enables pins 7..5
   logic [7:0]  pin_meta;
   logic [7:0]  pin_sync;
   logic [7:0]  next_latch;
   logic [7:0]  next_direction;
   logic [3:0]  next_func_en;
   logic        next_ack;
   logic [31:0] next_dat;
   logic [7:0]  next_pin_out;
   logic [7:0]  next_pin_oe_n;
   timer_in_s   next_timer_in;
   pin_fn_e     fn7;
   pin_fn_e     fn6;
   pin_fn_e     fn5;
   logic        access;
   logic [7:0]  readback;
   logic        a2_pwm1;
   logic        phase24;

   assign access = cyc_i && stb_i && !ack_o;
   assign readback = (direction & latch) | (~direction & pin_sync);

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   // one-wait answer: ack is raised the cycle after the request and held one cycle
   always_comb begin
      next_latch     = latch;
      next_direction = direction;
      next_func_en   = func_en;
      next_ack       = access;
      next_dat       = 32'h0000_0000;
      if (access && we_i && sel_i[0]) begin
         case (adr_i)
            `OFS_OUTPUT_LATCH: next_latch = dat_i[7:0];
            `OFS_DIRECTION:    next_direction = dat_i[7:0];
            `OFS_FUNC_ENABLE:  next_func_en = dat_i[3:0];
            default:           next_latch = latch;
         endcase
      end
      if (access && !we_i) begin
         case (adr_i)
            `OFS_OUTPUT_LATCH: next_dat = {24'h00_0000, latch};
            `OFS_PIN_READBACK: next_dat = {24'h00_0000, readback};
            `OFS_FUNC_ENABLE:  next_dat = {28'h000_0000, func_en};
            default:           next_dat = 32'h0000_0000;  // direction is write-only
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latch     <= `RST_LATCH;
         direction <= `RST_DIRECTION;
         func_en   <= `RST_FUNC_ENABLE;
         ack_o     <= 1'b0;
         dat_o     <= 32'h0000_0000;
      end else begin
         latch     <= next_latch;
         direction <= next_direction;
         func_en   <= next_func_en;
         ack_o     <= next_ack;
         dat_o     <= next_dat;
      end
   end

   // ----------------------------------------------------------------
   // pin sampling
   // ----------------------------------------------------------------
   // two-stage synchroniser
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta <= 8'h00;
         pin_sync <= 8'h00;
      end else begin
         pin_meta <= pin_i;
         pin_sync <= pin_meta;
      end
   end

   // ----------------------------------------------------------------
   // pin function select
   // ----------------------------------------------------------------
   assign a2_pwm1 = (timer_cfg_i.mode2 == `MODE_PWM1) && (timer_cfg_i.io_a2[1:0] != 2'b00);
   assign phase24 = (timer_cfg_i.mode2[3:2] == 2'b01) && (timer_cfg_i.mode4[3:2] == 2'b01);

   // timer output wins over the general-purpose choice
   always_comb begin
      // pwm1 on A blocks B drive
      if (compare_out(timer_cfg_i.mode2, timer_cfg_i.io_b2, timer_cfg_i.clear2, `CCLR_OWN_CH2_B)
          && !a2_pwm1) begin
         fn7 = FN_TIMER;
      end else begin
         fn7 = gp_fn(direction[7], func_en[3]);
      end
      if (compare_out(timer_cfg_i.mode2, timer_cfg_i.io_a2, timer_cfg_i.clear2, `CCLR_OWN_CH2_A)
          || a2_pwm1) begin
         fn6 = FN_TIMER;
      end else begin
         fn6 = gp_fn(direction[6], func_en[2]);
      end
      if (func_en[`FE_DMA_ACK1_BIT]) begin
         fn5 = FN_DMA;
      end else if (compare_out(timer_cfg_i.mode1, timer_cfg_i.io_b1, timer_cfg_i.clear1,
                               `CCLR_OWN_CH1_B)) begin
         fn5 = FN_TIMER;
      end else begin
         fn5 = gp_fn(direction[5], func_en[1]);
      end
   end

   // ----------------------------------------------------------------
   // pin drive and timer inputs
   // ----------------------------------------------------------------
   // shared pin outputs
   always_comb begin
      // low pins follow latch and direction
      next_pin_out       = latch;
      next_pin_oe_n      = ~direction;
      next_pin_out[7]    = (fn7 == FN_TIMER) ? periph_i.timer2_b :
                           (fn7 == FN_PULSE) ? periph_i.pulse15 : latch[7];
      next_pin_oe_n[7]   = (fn7 == FN_INPUT);
      next_pin_out[6]    = (fn6 == FN_TIMER) ? periph_i.timer2_a :
                           (fn6 == FN_PULSE) ? periph_i.pulse14 : latch[6];
      next_pin_oe_n[6]   = (fn6 == FN_INPUT);
      next_pin_out[5]    = (fn5 == FN_DMA)   ? periph_i.dma_ack1 :
                           (fn5 == FN_TIMER) ? periph_i.timer1_b :
                           (fn5 == FN_PULSE) ? periph_i.pulse13 : latch[5];
      next_pin_oe_n[5]   = (fn5 == FN_INPUT);
      // capture and clock paths take the pin regardless of its port function
      // capture B2
      next_timer_in.capture_b2  = capture_mode(timer_cfg_i.mode2) && timer_cfg_i.io_b2[3] && pin_sync[7];
      next_timer_in.capture_a2  = capture_mode(timer_cfg_i.mode2) && timer_cfg_i.io_a2[3] && pin_sync[6];
      next_timer_in.capture_b1  = capture_mode(timer_cfg_i.mode1) && (timer_cfg_i.io_b1[3:2] == 2'b10)
                                  && pin_sync[5];
      next_timer_in.ext_clock_d = ((timer_cfg_i.psc0 == `PSC_EXT_CD) || (timer_cfg_i.psc5 == `PSC_EXT_CD)
                                   || phase24) && pin_sync[7];
      next_timer_in.ext_clock_c = ((timer_cfg_i.psc0 == `PSC_EXT_CD) || (timer_cfg_i.psc2 == `PSC_EXT_CD)
                                   || (timer_cfg_i.psc4 == `PSC_EXT_C_ALT)
                                   || (timer_cfg_i.psc5 == `PSC_EXT_C_ALT) || phase24) && pin_sync[5];
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_out_o  <= 8'h00;
         pin_oe_n_o <= 8'hff;
         timer_in_o <= '0;
      end else begin
         pin_out_o  <= next_pin_out;
         pin_oe_n_o <= next_pin_oe_n;
         timer_in_o <= next_timer_in;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence wr_at(logic [3:0] ofs);
      access && we_i && sel_i[0] && (adr_i == ofs);
   endsequence

   a_latch_write: assert property (wr_at(`OFS_OUTPUT_LATCH) |=> latch == $past(dat_i[7:0]))
      else $error("latch did not take written data");
   a_readonly_write: assert property (wr_at(`OFS_PIN_READBACK) |=> $stable(latch) && $stable(direction))
      else $error("readback write changed state");
   a_readback_mix: assert property ((access && !we_i && adr_i == `OFS_PIN_READBACK)
      |=> dat_o[7:0] == (($past(direction) & $past(latch)) | (~$past(direction) & $past(pin_sync))))
      else $error("readback mix wrong");
   a_sync_delay: assert property (##2 1'b1 |-> pin_sync == $past(pin_i, 2))
      else $error("pin sampling not two stages");
   a_dack_override: assert property (func_en[`FE_DMA_ACK1_BIT]
      |=> !pin_oe_n_o[5] && pin_out_o[5] == $past(periph_i.dma_ack1))
      else $error("dma ack not on pin 5");
   a_b_disable: assert property (a2_pwm1 |-> fn7 != FN_TIMER ##1 !pin_oe_n_o[6])
      else $error("pwm1 did not block output B");
   a_pin7_pulse: assert property ((fn7 == FN_PULSE)
      |=> !pin_oe_n_o[7] && pin_out_o[7] == $past(periph_i.pulse15))
      else $error("pin 7 pulse output wrong");
   a_clock_d: assert property ((phase24 && pin_sync[7]) |=> timer_in_o.ext_clock_d)
      else $error("clock D not fed in phase mode");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held more than one cycle");

   // register answers: every taken request is acked next cycle
   a_ack_answer: assert property (access |=> ack_o)
      else $error("request not acked in one cycle");
   a_latch_readout: assert property ((access && !we_i && adr_i == `OFS_OUTPUT_LATCH)
      |=> dat_o == {24'h00_0000, $past(latch)})
      else $error("latch readout wrong");
   a_dir_write: assert property (wr_at(`OFS_DIRECTION) |=> direction == $past(dat_i[7:0]))
      else $error("direction did not take written data");
   a_dir_readzero: assert property ((access && !we_i && adr_i == `OFS_DIRECTION) |=> dat_o == 32'h0)
      else $error("write-only direction read back nonzero");

   // low pins are plain general-purpose pins
   a_low_oe: assert property (1'b1 |=> pin_oe_n_o[4:0] == ~$past(direction[4:0]))
      else $error("low pin enable does not follow direction");
   a_low_out: assert property (1'b1 |=> pin_out_o[4:0] == $past(latch[4:0]))
      else $error("low pin drive does not follow latch");

   // upper pin functions land on the registered pin drive
   a_pin7_input: assert property ((fn7 == FN_INPUT) |=> pin_oe_n_o[7])
      else $error("pin 7 driven while input");
   a_pin6_pulse: assert property ((fn6 == FN_PULSE)
      |=> !pin_oe_n_o[6] && pin_out_o[6] == $past(periph_i.pulse14))
      else $error("pin 6 pulse output wrong");
   a_pin5_timer: assert property ((fn5 == FN_TIMER)
      |=> !pin_oe_n_o[5] && pin_out_o[5] == $past(periph_i.timer1_b))
      else $error("pin 5 timer output wrong");

   // capture and clock inputs handed to the timer
   a_capture_a2: assert property ((capture_mode(timer_cfg_i.mode2) && timer_cfg_i.io_a2[3] && pin_sync[6])
      |=> timer_in_o.capture_a2)
      else $error("capture A2 not fed");
   a_capture_b1: assert property ((capture_mode(timer_cfg_i.mode1) && timer_cfg_i.io_b1[3:2] == 2'b10
      && pin_sync[5]) |=> timer_in_o.capture_b1)
      else $error("capture B1 not fed");
   a_clock_d_psc: assert property (((timer_cfg_i.psc0 == `PSC_EXT_CD) || (timer_cfg_i.psc5 == `PSC_EXT_CD))
      && pin_sync[7] |=> timer_in_o.ext_clock_d)
      else $error("clock D not fed by prescaler select");
   a_clock_c_psc: assert property ((timer_cfg_i.psc2 == `PSC_EXT_CD) && pin_sync[5]
      |=> timer_in_o.ext_clock_c)
      else $error("clock C not fed by prescaler select");

endmodule : port_pin_readback_data_and_pin_select

// *** tb/pin_board.sv ***
// Purpose: board side of the port 1 pins
// Assumes: each pin is either driven by the block or by the board
// Notes:   an undriven pin shows the level that the bench chooses
`timescale 1ns/1ps

// ---------------------------------------------------
// wired pin level
// ---------------------------------------------------
module pin_board (
   input  wire logic [7:0] drive_i,
   input  wire logic [7:0] oe_n_i,
   input  wire logic [7:0] ext_i,
   output logic      [7:0] pin_o
);
   // the block wins where it drives, so a readback of a driven pin is its own drive
   assign pin_o = (oe_n_i & ext_i) | (~oe_n_i & drive_i);
endmodule : pin_board

// *** tb/tb.sv ***
// Purpose: self-checking bench of the port 1 block
// Assumes: single-cycle Wishbone answer, two-flop pin synchroniser
// Notes:   levels are checked a few cycles after each change to let syncs settle
`timescale 1ns/1ps

module tb
   import port_pin_readback_pkg::*;
;
   logic        clk_i, rst_i, cyc, stb, we, ack_o;
   logic [3:0]  adr, sel;
   logic [31:0] dat_w, dat_o, rd;
   logic [7:0]  pin_i, pin_out_o, pin_oe_n_o, ext;
   timer_cfg_s  cfg;
   periph_out_s per;
   timer_in_s   tin;
   int          fails, comparisons;

   port_pin_readback_data_and_pin_select DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_o), .ack_o(ack_o), .pin_i(pin_i),
      .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .timer_cfg_i(cfg), .periph_i(per), .timer_in_o(tin));
   pin_board board (.drive_i(pin_out_o), .oe_n_i(pin_oe_n_o), .ext_i(ext), .pin_o(pin_i));

   // ---------------------------------------------------
   // shared tasks
   // ---------------------------------------------------
   task automatic test_done;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle; held until ack is sampled, no latency assumed
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat_w <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rd = dat_o;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask : bus

   task automatic settle;
      repeat (4) @(posedge clk_i);
      #1;
   endtask : settle

   task automatic drv(input timer_cfg_s c, input periph_out_s p, input logic [7:0] e);
      @(posedge clk_i);
      cfg <= c; per <= p; ext <= e;
      settle;
   endtask : drv

   // ---------------------------------------------------
   // scenarios
   // ---------------------------------------------------
   task automatic t_regs;
      bus(0, 4'h0, 0); chk(rd, 32'h0);
      bus(1, 4'h0, 32'ha5); bus(0, 4'h0, 0); chk(rd, 32'ha5);
      bus(1, 4'h4, 32'hff); bus(0, 4'h4, 0); chk(rd, 32'h3c);
      bus(0, 4'h8, 0); chk(rd, 32'h0);
      bus(1, 4'h2, 32'hff); bus(0, 4'h2, 0); chk(rd, 32'h0);
   endtask : t_regs

   task automatic t_capture;
      timer_cfg_s c;
      c = '0; c.psc0 = 3'h7;
      drv(c, '0, 8'h80); chk(tin, 5'b00010);
      c = '0; c.psc5 = 3'h7; c.psc4 = 3'h5;
      drv(c, '0, 8'ha0); chk(tin, 5'b00011);
      c = '0; c.mode2 = 4'h4; c.mode4 = 4'h4; c.io_a2 = 4'h8; c.io_b2 = 4'h8; c.io_b1 = 4'h8;
      drv(c, '0, 8'he0); chk(tin, 5'b11111);
      drv(c, '0, 8'h00); chk(tin, 5'b00000);
      c.io_b1 = 4'h4; c.mode2 = 4'h0; c.mode4 = 4'h0;
      drv(c, '0, 8'he0); chk(tin, 5'b11000);
      c = '0; c.psc2 = 3'h7;
      drv(c, '0, 8'h20); chk(tin, 5'b00001);
      drv('0, '0, 8'h3c);
   endtask : t_capture

   task automatic t_dir;
      bus(1, 4'h8, 32'hf0); settle;
      bus(0, 4'h4, 0); chk(rd, 32'hac);
      chk(pin_oe_n_o, 8'h0f);
      chk(pin_out_o[7:4], 4'ha);
      bus(1, 4'h8, 32'h00); settle;
      bus(0, 4'h4, 0); chk(rd, 32'h3c);
   endtask : t_dir

   task automatic t_func;
      periph_out_s p;
      p = '0;
      bus(1, 4'h8, 32'hf0); bus(1, 4'hc, 32'h9); settle;
      chk({pin_out_o[7], pin_out_o[5]}, 2'b00);
      p.pulse15 = 1'b1; p.dma_ack1 = 1'b1; drv('0, p, 8'h3c);
      chk({pin_out_o[7], pin_out_o[5]}, 2'b11);
      bus(1, 4'h8, 32'h00); bus(1, 4'h0, 32'h00); settle;
      chk({pin_oe_n_o[7], pin_oe_n_o[5], pin_out_o[5]}, 3'b101);
      bus(1, 4'hc, 32'h0); settle;
   endtask : t_func

   task automatic t_timer;
      timer_cfg_s  c;
      periph_out_s p;
      c = '0; p = '0; p.timer2_b = 1'b1; p.timer2_a = 1'b1;
      c.io_b2 = 4'h5; drv(c, p, 8'h00);
      chk({pin_oe_n_o[7], pin_out_o[7]}, 2'b01);
      c.mode2 = 4'h3; c.io_b2 = 4'h1; c.clear2 = 2'h2; drv(c, p, 8'h00);
      chk(pin_oe_n_o[7], 1'b1);
      c.clear2 = 2'h0; drv(c, p, 8'h00);
      chk(pin_oe_n_o[7], 1'b0);
      c.mode2 = 4'h2; c.io_a2 = 4'h1; drv(c, p, 8'h00);
      chk({pin_oe_n_o[7:6], pin_out_o[6]}, 3'b101);
   endtask : t_timer

   // ---------------------------------------------------
   // clock, reset, sequence, watchdog
   // ---------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   initial begin
      rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'hf; dat_w = '0;
      ext = 8'h3c; cfg = '0; per = '0; fails = 0; comparisons = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      t_regs;
      t_capture;
      t_dir;
      t_func;
      t_timer;
      test_done;
   end

   // the whole run needs well under a thousand cycles
   initial begin
      #40000;
      fails++;
      $display("mismatch at %0t: run timed out", $time);
      test_done;
   end
endmodule : tb
